// >>> rtl/tlpic_pkg.sv
package tlpic_pkg;

  // ---------------------------------------------------------------
  // Register map (word index on the plain register port).
  // ---------------------------------------------------------------
  localparam logic [2:0] ADDR_CTRL_MAIN = 3'h0;
  localparam logic [2:0] ADDR_EDGE_PRIO = 3'h1;
  localparam logic [2:0] ADDR_EXT_PIN = 3'h2;
  localparam logic [2:0] ADDR_RESET_CTRL = 3'h3;
  localparam logic [2:0] ADDR_PERIPH_FLAG = 3'h4;
  localparam logic [2:0] ADDR_PERIPH_EN = 3'h5;
  localparam logic [2:0] ADDR_PERIPH_PRIO = 3'h6;

  // ---------------------------------------------------------------
  // Field positions.
  // ---------------------------------------------------------------
  localparam int CM_HIGH_EN = 7;
  localparam int CM_LOW_EN = 6;
  localparam int CM_T0_EN = 5;
  localparam int CM_P0_EN = 4;
  localparam int CM_PC_EN = 3;
  localparam int CM_T0_FLAG = 2;
  localparam int CM_P0_FLAG = 1;
  localparam int CM_PC_FLAG = 0;
  localparam int EP_PULLUP_DIS = 7;
  localparam int EP_EDGE0 = 6;
  localparam int EP_EDGE1 = 5;
  localparam int EP_EDGE2 = 4;
  localparam int EP_T0_PRIO = 2;
  localparam int EP_PC_PRIO = 0;
  localparam int XP_P2_PRIO = 7;
  localparam int XP_P1_PRIO = 6;
  localparam int XP_P2_EN = 4;
  localparam int XP_P1_EN = 3;
  localparam int XP_P2_FLAG = 1;
  localparam int XP_P1_FLAG = 0;
  localparam int RC_PRIO_MODE = 7;

  // ---------------------------------------------------------------
  // Reset values and implemented-bit masks.
  // ---------------------------------------------------------------
  localparam logic [7:0] RST_CTRL_MAIN = 8'h00;
  localparam logic [7:0] RST_EDGE_PRIO = 8'hF5;
  localparam logic [7:0] RST_EXT_PIN = 8'hC0;
  localparam logic [7:0] MASK_EDGE_PRIO = 8'hF5;
  localparam logic [7:0] MASK_EXT_PIN = 8'hDB;

  // ---------------------------------------------------------------
  // Vectors and timing.
  // ---------------------------------------------------------------
  localparam logic [20:0] VEC_HIGH = 21'h000008;
  localparam logic [20:0] VEC_LOW = 21'h000018;
  localparam int EXT_LAT_MIN_CYC = 3;
  localparam int EXT_LAT_MAX_CYC = 4;

  // Service level of the core.
  typedef enum logic [1:0] {
    TLPIC_IDLE = 2'b00,
    TLPIC_LOW = 2'b01,
    TLPIC_HIGH = 2'b10
  } tlpic_level_t;

endpackage : tlpic_pkg

// >>> rtl/tlpic_top.sv
// The strobed register port and the register addresses were left to the implementer.
`timescale 1ns/1ps
`default_nettype none

module tlpic_top
  import tlpic_pkg::*;
#(
  parameter int NUM_PERIPH = 8
) (
  // Clock, reset and freeze.
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic clkEn,
  // Register port.
  input wire logic [2:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [7:0] regRdData,
  // Event sources.
  input wire logic timerOverflow,
  input wire logic [2:0] extPin,
  input wire logic [3:0] portUpper,
  input wire logic [7:0] portLatch,
  input wire logic [NUM_PERIPH-1:0] periphEvent,
  // Core handshake.
  input wire logic vectorAck,
  input wire logic [20:0] returnPc,
  input wire logic returnFromIrq,
  output logic vectorReq,
  output logic [20:0] vectorAddr,
  output logic stackPush,
  output logic [20:0] stackData,
  output logic [7:0] pullupEn
);

  // ---------------------------------------------------------------
  // Checks.
  // ---------------------------------------------------------------
  // Refuse peripheral counts that the 8-bit register port cannot show.
  if (NUM_PERIPH < 1 || NUM_PERIPH > 8) begin : gBadPeriph
    $error("NUM_PERIPH must lie between 1 and 8.");
  end

  // ---------------------------------------------------------------
  // State.
  // ---------------------------------------------------------------
  logic [7:0] ctrlMain;
  logic [7:0] edgePrio;
  logic [7:0] extCtrl;
  logic prioMode;
  logic [NUM_PERIPH-1:0] perFlag;
  logic [NUM_PERIPH-1:0] perEn;
  logic [NUM_PERIPH-1:0] perPrio;
  logic [2:0] pinPrev;
  logic [3:0] portPrev;
  logic [2:0] pinStage;
  logic [3:0] portStage;
  tlpic_level_t level;
  tlpic_level_t stackLevel;
  logic [2:0] pinRise;
  logic [2:0] pinFall;
  logic [2:0] pinHit;
  logic portHit;
  logic hiReq;
  logic loReq;
  logic anyReq;
  logic takeHigh;
  logic take;
  logic [6:0] srcFlag;
  logic [6:0] srcEn;
  logic [6:0] srcPrio;
  logic [6:0] srcPeriph;

  // Write strobe for one register index.
  function automatic logic wrHit(input logic [2:0] idx);
    wrHit = regWrite && (regAddr == idx);
  endfunction : wrHit

  // Edge detection of the pins and the upper port nibble.
  assign pinRise = pinStage & ~pinPrev;
  assign pinFall = ~pinStage & pinPrev;
  // Edge selection per pin.
  assign pinHit[0] = edgePrio[EP_EDGE0] ? pinRise[0] : pinFall[0];
  assign pinHit[1] = edgePrio[EP_EDGE1] ? pinRise[1] : pinFall[1];
  assign pinHit[2] = edgePrio[EP_EDGE2] ? pinRise[2] : pinFall[2];
  assign portHit = |(portStage ^ portPrev);

  // Input stage, then previous levels. The stage brings the pin and
  // port-change request to the core three cycles after the edge.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pinStage <= 3'h0;
      portStage <= 4'h0;
      pinPrev <= 3'h0;
      portPrev <= 4'h0;
    end else if (clkEn) begin
      pinStage <= extPin;
      portStage <= portUpper;
      pinPrev <= pinStage;
      portPrev <= portStage;
    end
  end

  // ---------------------------------------------------------------
  // Source table: flag, enable, priority, peripheral-group mark.
  // ---------------------------------------------------------------
  assign srcFlag = {|(perFlag & perEn & perPrio),
    |(perFlag & perEn & ~perPrio), extCtrl[XP_P2_FLAG],
    extCtrl[XP_P1_FLAG], ctrlMain[CM_T0_FLAG], ctrlMain[CM_P0_FLAG],
    ctrlMain[CM_PC_FLAG]};
  assign srcEn = {2'b11, extCtrl[XP_P2_EN], extCtrl[XP_P1_EN],
    ctrlMain[CM_T0_EN], ctrlMain[CM_P0_EN], ctrlMain[CM_PC_EN]};
  // Pin 0 has no priority bit and is always high level.
  assign srcPrio = {1'b1, 1'b0, extCtrl[XP_P2_PRIO], extCtrl[XP_P1_PRIO],
    edgePrio[EP_T0_PRIO], 1'b1, edgePrio[EP_PC_PRIO]};
  assign srcPeriph = 7'h60;

  // Request gating per mode.
  always_comb begin
    hiReq = 1'b0;
    loReq = 1'b0;
    anyReq = 1'b0;
    for (int i = 0; i < 7; i++) begin
      if (srcFlag[i] && srcEn[i]) begin
        if (srcPrio[i]) begin
          hiReq = 1'b1;
        end else begin
          loReq = 1'b1;
        end
        if (!srcPeriph[i] || ctrlMain[CM_LOW_EN]) begin
          anyReq = 1'b1;
        end
      end
    end
  end

  // Acceptance; high preempts low, low never preempts high.
  assign takeHigh = prioMode && hiReq && ctrlMain[CM_HIGH_EN] &&
    (level != TLPIC_HIGH);
  assign take = !vectorReq && (prioMode ? (takeHigh ||
    (loReq && ctrlMain[CM_LOW_EN] && level == TLPIC_IDLE)) :
    (anyReq && ctrlMain[CM_HIGH_EN]));

  // ---------------------------------------------------------------
  // Vector request to the core.
  // ---------------------------------------------------------------
  // Request held until the core acknowledges the fetch.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      vectorReq <= 1'b0;
      vectorAddr <= VEC_HIGH;
      stackPush <= 1'b0;
      stackData <= 21'h000000;
    end else if (clkEn) begin
      stackPush <= take;
      if (take) begin
        vectorReq <= 1'b1;
        stackData <= returnPc;
        vectorAddr <= (prioMode && !takeHigh) ? VEC_LOW : VEC_HIGH;
      end else if (vectorAck) begin
        vectorReq <= 1'b0;
      end
    end
  end

  // Service level tracking for preemption and return.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      level <= TLPIC_IDLE;
      stackLevel <= TLPIC_IDLE;
    end else if (clkEn) begin
      if (take) begin
        stackLevel <= level;
        level <= (prioMode && takeHigh) ? TLPIC_HIGH : TLPIC_LOW;
      end else if (returnFromIrq) begin
        level <= stackLevel;
        stackLevel <= TLPIC_IDLE;
      end
    end
  end

  // ---------------------------------------------------------------
  // Registers. Hardware set wins over software clear.
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrlMain <= RST_CTRL_MAIN;
    end else if (clkEn) begin
      if (wrHit(ADDR_CTRL_MAIN)) begin
        ctrlMain <= regWrData;
      end
      if (take) begin
        // Clear the enable in force.
        if (prioMode && !takeHigh) begin
          ctrlMain[CM_LOW_EN] <= 1'b0;
        end else begin
          ctrlMain[CM_HIGH_EN] <= 1'b0;
        end
      end else if (returnFromIrq) begin
        // Re-enable for the level being left.
        if (prioMode && level == TLPIC_LOW) begin
          ctrlMain[CM_LOW_EN] <= 1'b1;
        end else begin
          ctrlMain[CM_HIGH_EN] <= 1'b1;
        end
      end
      // Flags are only ever set by hardware here.
      if (timerOverflow) begin
        ctrlMain[CM_T0_FLAG] <= 1'b1;
      end
      if (pinHit[0]) begin
        ctrlMain[CM_P0_FLAG] <= 1'b1;
      end
      if (portHit) begin
        ctrlMain[CM_PC_FLAG] <= 1'b1;
      end
    end
  end

  // Edge/priority and pin registers keep unimplemented bits zero.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      edgePrio <= RST_EDGE_PRIO;
      extCtrl <= RST_EXT_PIN;
      prioMode <= 1'b0;
    end else if (clkEn) begin
      if (wrHit(ADDR_EDGE_PRIO)) begin
        edgePrio <= regWrData & MASK_EDGE_PRIO;
      end
      if (wrHit(ADDR_EXT_PIN)) begin
        extCtrl <= regWrData & MASK_EXT_PIN;
      end
      if (wrHit(ADDR_RESET_CTRL)) begin
        prioMode <= regWrData[RC_PRIO_MODE];
      end
      if (pinHit[1]) begin
        extCtrl[XP_P1_FLAG] <= 1'b1;
      end
      if (pinHit[2]) begin
        extCtrl[XP_P2_FLAG] <= 1'b1;
      end
    end
  end

  // Peripheral flag, enable and priority bits, one per source.
  genvar g;
  generate
    for (g = 0; g < NUM_PERIPH; g++) begin : gPer
      always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
          perFlag[g] <= 1'b0;
          perEn[g] <= 1'b0;
          perPrio[g] <= 1'b1;
        end else if (clkEn) begin
          if (wrHit(ADDR_PERIPH_FLAG)) begin
            perFlag[g] <= regWrData[g];
          end
          if (periphEvent[g]) begin
            perFlag[g] <= 1'b1;
          end
          if (wrHit(ADDR_PERIPH_EN)) begin
            perEn[g] <= regWrData[g];
          end
          if (wrHit(ADDR_PERIPH_PRIO)) begin
            perPrio[g] <= regWrData[g];
          end
        end
      end
    end
  endgenerate

  // Read data appear in the cycle after the read strobe.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      regRdData <= 8'h00;
    end else if (clkEn) begin
      regRdData <= 8'h00;
      if (regRead) begin
        case (regAddr)
          ADDR_CTRL_MAIN: regRdData <= ctrlMain;
          ADDR_EDGE_PRIO: regRdData <= edgePrio;
          ADDR_EXT_PIN: regRdData <= extCtrl;
          ADDR_RESET_CTRL: regRdData <= {prioMode, 7'h00};
          ADDR_PERIPH_FLAG: regRdData <= 8'(perFlag);
          ADDR_PERIPH_EN: regRdData <= 8'(perEn);
          ADDR_PERIPH_PRIO: regRdData <= 8'(perPrio);
          default: regRdData <= 8'h00;
        endcase
      end
    end
  end

  // Pull-up enables per port bit.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pullupEn <= 8'h00;
    end else if (clkEn) begin
      pullupEn <= edgePrio[EP_PULLUP_DIS] ? 8'h00 : portLatch;
    end
  end

  // ---------------------------------------------------------------
  // Checks on the behaviour.
  // ---------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  // Acceptance in one enabled cycle; six of the fifteen checks start from it.
  sequence sTake;
    clkEn && take;
  endsequence

  // Return instruction seen with no acceptance in the same cycle.
  sequence sReturn;
    clkEn && returnFromIrq && !take;
  endsequence

  a_vec_compat: assert property (
    sTake and !prioMode |=> vectorReq && vectorAddr == VEC_HIGH)
    else $error("Bad compat vector.");
  a_vec_low: assert property (
    sTake and (prioMode && !takeHigh) |=> vectorAddr == VEC_LOW)
    else $error("Bad low vector.");
  a_vec_high: assert property (
    sTake and (prioMode && takeHigh) |=> vectorAddr == VEC_HIGH)
    else $error("Bad high vector.");
  a_no_low_preempt: assert property (
    clkEn && prioMode && level == TLPIC_HIGH && !vectorReq |=> !vectorReq)
    else $error("High service was preempted.");
  a_clear_enable: assert property (
    sTake and !prioMode |=> !ctrlMain[CM_HIGH_EN])
    else $error("Enable not cleared.");
  a_push_return: assert property (
    sTake |=> stackPush && stackData == $past(returnPc))
    else $error("No push.");
  a_req_held: assert property (
    clkEn && vectorReq && !vectorAck |=> vectorReq)
    else $error("Vector request dropped early.");
  a_return_low: assert property (
    sReturn and (prioMode && level == TLPIC_LOW) |=> ctrlMain[CM_LOW_EN])
    else $error("Low enable not restored.");
  a_return_high: assert property (
    sReturn and !(prioMode && level == TLPIC_LOW) |=> ctrlMain[CM_HIGH_EN])
    else $error("High enable not restored.");
  a_timer_flag: assert property (
    clkEn && timerOverflow |=> ctrlMain[CM_T0_FLAG])
    else $error("Timer flag lost.");
  a_pin_flag: assert property (
    clkEn && pinHit[1] |=> extCtrl[XP_P1_FLAG])
    else $error("Pin flag lost.");
  a_pin0_edge: assert property (
    clkEn && pinStage[0] != pinPrev[0] && edgePrio[EP_EDGE0] == pinStage[0]
    |=> ctrlMain[CM_P0_FLAG]) else $error("Pin 0 edge missed.");
  a_pullup_off: assert property (
    clkEn && edgePrio[EP_PULLUP_DIS] |=> pullupEn == 8'h00)
    else $error("Pull-ups not disabled.");
  a_unimpl_zero: assert property (
    (edgePrio & ~MASK_EDGE_PRIO) == 8'h00 && (extCtrl & ~MASK_EXT_PIN) == 8'h00)
    else $error("Bad spare bit.");
  a_periph_gate: assert property (
    sTake and (!prioMode && !ctrlMain[CM_LOW_EN]) |-> |(srcFlag[4:0] & srcEn[4:0]))
    else $error("Peripheral gate ignored.");

endmodule : tlpic_top
`default_nettype wire

// >>> dv/tlpic_core_model.sv
`timescale 1ns/1ps
`default_nettype none
// ---------------------------------------------------------------
// Core model that fetches the vector after a chosen delay.
// ---------------------------------------------------------------
module tlpic_core_model
  import tlpic_pkg::*;
(
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic rst_n,
  // Vector fetch handshake.
  input wire logic vectorReq,
  input wire logic [3:0] ackDelay,
  output logic vectorAck
);
  logic [3:0] waitCnt;

  // Counts the wait of a pending fetch, then pulses the acknowledge once.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      waitCnt <= 4'h0;
      vectorAck <= 1'b0;
    end else begin
      waitCnt <= (vectorReq && !vectorAck) ? waitCnt + 4'h1 : 4'h0;
      vectorAck <= vectorReq && !vectorAck && waitCnt == ackDelay;
    end
  end
endmodule : tlpic_core_model
`default_nettype wire

// >>> dv/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench
  import tlpic_pkg::*;
;
  // ---------------------------------------------------------------
  // Signals, instances and shared tasks.
  // ---------------------------------------------------------------
  logic sys_clk, rst_n, clkEn, regWrite, regRead, timerOverflow;
  logic returnFromIrq, vectorAck, vectorReq, stackPush;
  logic [2:0] regAddr, extPin;
  logic [3:0] portUpper, ackDelay;
  logic [7:0] regWrData, regRdData, portLatch, periphEvent, pullupEn, d;
  logic [20:0] returnPc, vectorAddr, stackData;
  int fails, n_checks, i, n;

  tlpic_top #(.NUM_PERIPH(8)) tlpic_top_i (.sys_clk(sys_clk), .rst_n(rst_n),
    .clkEn(clkEn), .regAddr(regAddr), .regWrData(regWrData),
    .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
    .timerOverflow(timerOverflow), .extPin(extPin), .portUpper(portUpper),
    .portLatch(portLatch), .periphEvent(periphEvent), .vectorAck(vectorAck),
    .returnPc(returnPc), .returnFromIrq(returnFromIrq),
    .vectorReq(vectorReq), .vectorAddr(vectorAddr), .stackPush(stackPush),
    .stackData(stackData), .pullupEn(pullupEn));

  tlpic_core_model tlpic_core_model_i (.sys_clk(sys_clk), .rst_n(rst_n),
    .vectorReq(vectorReq), .ackDelay(ackDelay), .vectorAck(vectorAck));

  // Prints the counts and the verdict, then ends the run.
  task automatic summarize;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : summarize

  // Compares one result and counts it.
  task automatic chk(input logic [20:0] got, input logic [20:0] exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // One-cycle register write.
  task automatic wr(input logic [2:0] a, input logic [7:0] v);
    @(posedge sys_clk);
    regAddr <= a;
    regWrData <= v;
    regWrite <= 1'b1;
    @(posedge sys_clk);
    regWrite <= 1'b0;
  endtask : wr

  // One-cycle register read; the data stand in the following cycle.
  task automatic rc(input logic [2:0] a, input logic [7:0] v);
    @(posedge sys_clk);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge sys_clk);
    regRead <= 1'b0;
    #1 chk(regRdData, v);
  endtask : rc

  // Single-cycle timer overflow pulse.
  task automatic pulseTimer;
    @(posedge sys_clk) timerOverflow <= 1'b1;
    @(posedge sys_clk) timerOverflow <= 1'b0;
  endtask : pulseTimer

  // Return instruction from the core.
  task automatic ret;
    @(posedge sys_clk) returnFromIrq <= 1'b1;
    @(posedge sys_clk) returnFromIrq <= 1'b0;
  endtask : ret

  // Waits for a vector, checks it, then waits for the fetch to finish.
  task automatic svc(input logic [20:0] vec, output int cnt);
    cnt = 0;
    while (vectorReq !== 1'b1 && cnt < 20) begin
      @(posedge sys_clk);
      #1 cnt++;
    end
    if (cnt == 20) begin
      fails++;
      summarize();
    end
    chk(vectorAddr, vec);
    chk(stackPush, 1'b1);
    chk(stackData, returnPc);
    for (i = 0; i < 20 && vectorReq === 1'b1; i++) begin
      @(posedge sys_clk);
      #1;
    end
    chk(vectorReq, 1'b0);
  endtask : svc

  // Free-running bench clock.
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  // ---------------------------------------------------------------
  // Main sequence.
  // ---------------------------------------------------------------
  initial begin
    {rst_n, regWrite, regRead, timerOverflow, returnFromIrq} = 5'h00;
    {regAddr, extPin, portUpper, ackDelay} = 14'h0000;
    {regWrData, portLatch, periphEvent, returnPc} = 45'h0;
    clkEn = 1'b1;
    fails = 0;
    n_checks = 0;
    void'($urandom(62250));
    repeat (20) @(posedge sys_clk);
    rst_n <= 1'b1;
    rc(ADDR_CTRL_MAIN, RST_CTRL_MAIN);
    rc(ADDR_EDGE_PRIO, RST_EDGE_PRIO);
    rc(ADDR_EXT_PIN, RST_EXT_PIN);
    wr(3'h7, 8'hFF);
    rc(3'h7, 8'h00);
    for (n = 0; n < 4; n++) begin
      d = 8'($urandom);
      wr(ADDR_EDGE_PRIO, d);
      rc(ADDR_EDGE_PRIO, d & MASK_EDGE_PRIO);
      d = 8'($urandom);
      wr(ADDR_EXT_PIN, d);
      rc(ADDR_EXT_PIN, d & MASK_EXT_PIN);
      @(posedge sys_clk) portLatch <= 8'($urandom);
      wr(ADDR_EDGE_PRIO, {n[0], 7'h75});
      repeat (2) @(posedge sys_clk);
      #1 chk(pullupEn, n[0] ? 8'h00 : portLatch);
    end
    wr(ADDR_EXT_PIN, 8'h00);
    $display("test registers done");
    // Flags are set with every enable off, and an event beats a clear.
    pulseTimer();
    rc(ADDR_CTRL_MAIN, 8'h04);
    @(posedge sys_clk);
    {timerOverflow, regWrite, regAddr, regWrData} <= {2'b11, 11'h000};
    @(posedge sys_clk);
    {timerOverflow, regWrite} <= 2'b00;
    rc(ADDR_CTRL_MAIN, 8'h04);
    @(posedge sys_clk) portUpper <= 4'h1 + 4'($urandom % 15);
    repeat (3) @(posedge sys_clk);
    #1 chk(vectorReq, 1'b0);
    rc(ADDR_CTRL_MAIN, 8'h05);
    wr(ADDR_CTRL_MAIN, 8'h00);
    n = $urandom % 8;
    @(posedge sys_clk) periphEvent <= 8'h01 << n;
    @(posedge sys_clk) periphEvent <= 8'h00;
    rc(ADDR_PERIPH_FLAG, 8'h01 << n);
    wr(ADDR_PERIPH_FLAG, 8'h00);
    $display("test polling done");
    // Each edge select catches its own edge and ignores the other one.
    for (n = 0; n < 2; n++) begin
      @(posedge sys_clk) extPin <= {3{~n[0]}};
      wr(ADDR_EDGE_PRIO, {1'b1, {3{n[0]}}, 4'h5});
      wr(ADDR_CTRL_MAIN, 8'h00);
      wr(ADDR_EXT_PIN, RST_EXT_PIN);
      extPin <= {3{n[0]}};
      repeat (4) @(posedge sys_clk);
      rc(ADDR_CTRL_MAIN, 8'h02);
      rc(ADDR_EXT_PIN, 8'hC3);
      wr(ADDR_CTRL_MAIN, 8'h00);
      wr(ADDR_EXT_PIN, RST_EXT_PIN);
      extPin <= {3{~n[0]}};
      repeat (4) @(posedge sys_clk);
      rc(ADDR_CTRL_MAIN, 8'h00);
      rc(ADDR_EXT_PIN, RST_EXT_PIN);
    end
    $display("test edges done");
    // Compatibility mode: one vector, master and peripheral enables.
    @(posedge sys_clk) returnPc <= 21'($urandom);
    ackDelay <= 4'($urandom % 6);
    wr(ADDR_EDGE_PRIO, 8'h71);
    wr(ADDR_CTRL_MAIN, 8'hA0);
    pulseTimer();
    svc(VEC_HIGH, n);
    rc(ADDR_CTRL_MAIN, 8'h24);
    wr(ADDR_CTRL_MAIN, 8'h20);
    ret();
    rc(ADDR_CTRL_MAIN, 8'hA0);
    wr(ADDR_PERIPH_EN, 8'h01);
    @(posedge sys_clk) periphEvent <= 8'h01;
    @(posedge sys_clk) periphEvent <= 8'h00;
    repeat (4) @(posedge sys_clk);
    #1 chk(vectorReq, 1'b0);
    wr(ADDR_CTRL_MAIN, 8'hC0);
    svc(VEC_HIGH, n);
    wr(ADDR_PERIPH_FLAG, 8'h00);
    wr(ADDR_PERIPH_EN, 8'h00);
    ret();
    wr(ADDR_CTRL_MAIN, 8'h90);
    @(posedge sys_clk) extPin <= 3'b001;
    svc(VEC_HIGH, n);
    chk(n >= EXT_LAT_MIN_CYC && n <= EXT_LAT_MAX_CYC, 1'b1);
    wr(ADDR_CTRL_MAIN, 8'h10);
    ret();
    $display("test compatibility done");
    // Priority mode: low vector, preemption by high, none by low.
    returnPc <= 21'($urandom);
    ackDelay <= 4'($urandom % 6);
    wr(ADDR_RESET_CTRL, 8'h80);
    wr(ADDR_EXT_PIN, 8'h48);
    wr(ADDR_CTRL_MAIN, 8'hE0);
    pulseTimer();
    svc(VEC_LOW, n);
    rc(ADDR_CTRL_MAIN, 8'hA4);
    @(posedge sys_clk) extPin <= 3'b011;
    svc(VEC_HIGH, n);
    rc(ADDR_CTRL_MAIN, 8'h24);
    wr(ADDR_EXT_PIN, 8'h48);
    ret();
    rc(ADDR_CTRL_MAIN, 8'hA4);
    wr(ADDR_CTRL_MAIN, 8'hA0);
    ret();
    rc(ADDR_CTRL_MAIN, 8'hE0);
    @(posedge sys_clk) extPin <= 3'b001;
    @(posedge sys_clk) extPin <= 3'b011;
    svc(VEC_HIGH, n);
    pulseTimer();
    repeat (6) @(posedge sys_clk);
    #1 chk(vectorReq, 1'b0);
    wr(ADDR_EXT_PIN, 8'h48);
    ret();
    svc(VEC_LOW, n);
    wr(ADDR_CTRL_MAIN, 8'h00);
    ret();
    $display("test priority done");
    // A frozen clock enable drops a write.
    @(posedge sys_clk) clkEn <= 1'b0;
    wr(ADDR_EXT_PIN, 8'hFF);
    clkEn <= 1'b1;
    rc(ADDR_EXT_PIN, 8'h48);
    $display("test freeze done");
    summarize();
  end
endmodule : testbench
`default_nettype wire
